// ==== inc/rom_bank_pkg.sv ====
// Purpose: Shared constants, types and helpers for the ROM bank and table address block.
// Assumes: Register indexes are multiplied by four to give AHB byte addresses.
// Notes: Bank window is 8192 words; the address width is cut per variant.
//
// Operation
// - Current table address is high[1:0], mid[7:0], low[7:0] from msb to lsb, with no bank bits.
// - Table address width is a variant parameter of 18, 17, 16 or 15 bits.
// - Program ROM is split into 8192-word banks, 32/24/16/12/8/4 banks per variant.
// - A written bank pointer takes effect only after a jump, call or interrupt.
// - Bank pointer value N selects word addresses N*2000h through N*2000h+1FFFh.
// - Only the low five, four, three or two bank pointer bits take effect.
// - Bank pointer is an 8-bit register at data-memory location 2DH.
// - Two table reads: full pointer, or last page of the selected bank.
// - Low byte goes to the destination; high byte goes to a read-only register.
// - Every table read completes in two cycles.
package rom_bank_pkg;
    localparam int ROM_ADDR_W = 18;
    localparam int PAGE_BITS = 13;
    localparam int BANK_SEL_W = 5;
    localparam int TBL_CYCLES = 2;
    localparam logic [4:0] LAST_PAGE_SEL = 5'h1F;
    localparam logic [7:0] IDX_TBL_LOW = 8'h07;
    localparam logic [7:0] IDX_TBL_HIGH_BYTE = 8'h08;
    localparam logic [7:0] IDX_TBL_MID = 8'h2B;
    localparam logic [7:0] IDX_TBL_HIGH = 8'h2C;
    localparam logic [7:0] IDX_BANK = 8'h2D;
    localparam logic [7:0] IDX_CMD = 8'h40;
    localparam logic [7:0] IDX_RESULT = 8'h41;
    localparam logic [7:0] IDX_STATUS = 8'h42;
    localparam logic [7:0] RST_TBL_PTR = 8'h00;
    localparam logic [7:0] RST_BANK = 8'h00;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_LAST_PAGE_BIT = 1;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_PEND_BIT = 1;
    localparam int STATUS_BANK_LSB = 8;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] mid;
        logic [7:0] low;
    } tbl_ptr_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA = 3'b100
    } tbl_state_type;

    // Mask keeping only the low width bits of a ROM word address
    function automatic logic [ROM_ADDR_W-1:0] low_mask(input int width);
        logic [ROM_ADDR_W-1:0] m;
        m = '0;
        for (int i = 0; i < ROM_ADDR_W; i++) begin
            if (i < width) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : low_mask

    // Register index of an AHB byte address
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        return addr[9:2];
    endfunction : reg_index
endpackage : rom_bank_pkg

// ==== logic/rom_addr_former.sv ====
// Purpose: Forms fetch and table-read ROM word addresses.
// Assumes: Bank and pointers are stable for the cycle in which they are sampled.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module rom_addr_former
    import rom_bank_pkg::*;
#(
    parameter int ADDR_WIDTH = 18
) (
    // Pointers and bank
    input wire tbl_ptr_type ptr,
    input wire logic [BANK_SEL_W-1:0] active_bank,
    input wire logic last_page,
    input wire logic [PAGE_BITS-1:0] pc_low,
    // Formed addresses
    output logic [ROM_ADDR_W-1:0] table_addr,
    output logic [ROM_ADDR_W-1:0] fetch_addr
);
    wire [ROM_ADDR_W-1:0] width_mask = low_mask(ADDR_WIDTH);
    wire [ROM_ADDR_W-1:0] cur_addr = {ptr.high[1:0], ptr.mid[7:5], ptr.mid[4:0], ptr.low};
    wire [ROM_ADDR_W-1:0] page_addr = {active_bank, LAST_PAGE_SEL, ptr.low};

    // Upper pointer and bank bits vanish under the variant mask
    assign table_addr = width_mask & (last_page ? page_addr : cur_addr);
    assign fetch_addr = width_mask & {active_bank, pc_low};
endmodule : rom_addr_former

// ==== logic/rom_bank_table.sv ====
// Purpose: ROM bank selection and table-read sequencing behind an AHB-Lite register slave.
// Assumes: Program ROM is synchronous with one cycle of read latency; CPU ports are on hclk.
// Notes: A table read takes the ROM port for two cycles; fetch_stall tells the sequencer.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
module rom_bank_table
    import rom_bank_pkg::*;
#(
    parameter int ADDR_WIDTH = 18,
    parameter int BANK_COUNT = 32
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // CPU sequencer
    input wire logic branch_done,
    input wire logic [PAGE_BITS-1:0] pc_low,
    input wire logic tbl_req,
    input wire logic tbl_last_page,
    output logic tbl_busy,
    output logic fetch_stall,
    output logic tbl_done,
    output logic [7:0] tbl_low_byte,
    output logic [7:0] table_high_byte,
    // Program ROM
    output logic [ROM_ADDR_W-1:0] rom_addr,
    input wire logic [15:0] rom_data
);
    tbl_ptr_type ptr;
    logic [7:0] rom_bank_select;
    logic [BANK_SEL_W-1:0] active_bank;
    tbl_state_type state;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic sw_pend;
    logic sw_kind;
    logic [31:0] rd_value;
    logic [ROM_ADDR_W-1:0] table_addr;
    logic [ROM_ADDR_W-1:0] fetch_addr;

    // Registers that plain data writes may overwrite
    function automatic logic is_rw(input logic [7:0] idx);
        return idx == IDX_TBL_LOW || idx == IDX_TBL_MID || idx == IDX_TBL_HIGH || idx == IDX_BANK;
    endfunction : is_rw

    // Bus decode
    wire addr_phase = hsel && hready && htrans == HTRANS_NONSEQ;
    wire addr_ok = haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0;
    wire [7:0] addr_idx = addr_ok ? reg_index(haddr) : 8'hFF;
    wire we_low = wr_pend && wr_idx == IDX_TBL_LOW;
    wire we_mid = wr_pend && wr_idx == IDX_TBL_MID;
    wire we_high = wr_pend && wr_idx == IDX_TBL_HIGH;
    wire we_bank = wr_pend && wr_idx == IDX_BANK;
    wire we_cmd = wr_pend && wr_idx == IDX_CMD && hwdata[CMD_START_BIT];
    wire fwd = wr_pend && wr_idx == addr_idx && is_rw(addr_idx);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Table-read sequencing
    wire idle = state == ST_IDLE;
    wire start = idle && (tbl_req || sw_pend);
    wire start_kind = tbl_req ? tbl_last_page : sw_kind;
    wire sw_taken = start && !tbl_req;
    wire next_sw_pend = we_cmd || (sw_pend && !sw_taken);
    wire [BANK_SEL_W-1:0] bank_eff = rom_bank_select[BANK_SEL_W-1:0];
    wire tbl_state_type next_state = start ? ST_ADDR : (state == ST_ADDR ? ST_DATA : ST_IDLE);
    wire [ROM_ADDR_W-1:0] next_rom_addr = start ? table_addr : (state == ST_ADDR ? rom_addr : fetch_addr);

    assign tbl_busy = !idle;
    assign fetch_stall = !idle || start;

    rom_addr_former #(
        .ADDR_WIDTH(ADDR_WIDTH)
    ) u_former (
        .ptr(ptr),
        .active_bank(active_bank),
        .last_page(start_kind),
        .pc_low(pc_low),
        .table_addr(table_addr),
        .fetch_addr(fetch_addr)
    );

    always_comb begin
        rd_value = 32'h00000000;
        unique case (addr_idx)
            IDX_TBL_LOW: rd_value[7:0] = ptr.low;
            IDX_TBL_MID: rd_value[7:0] = ptr.mid;
            IDX_TBL_HIGH: rd_value[7:0] = ptr.high;
            IDX_BANK: rd_value[7:0] = rom_bank_select;
            IDX_TBL_HIGH_BYTE: rd_value[7:0] = table_high_byte;
            IDX_RESULT: rd_value[7:0] = tbl_low_byte;
            IDX_CMD: rd_value[CMD_LAST_PAGE_BIT] = sw_kind;
            IDX_STATUS: rd_value = {16'h0000, {(8-BANK_SEL_W){1'b0}}, active_bank, 6'h00, sw_pend, tbl_busy};
            default: rd_value = 32'h00000000;
        endcase
        // Back-to-back write then read of one pointer or bank register sees the new value
        if (fwd) begin
            rd_value = {24'h000000, hwdata[7:0]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend <= addr_phase && hwrite;
            wr_idx <= addr_idx;
            if (addr_phase && !hwrite) begin
                hrdata <= rd_value;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr <= {RST_TBL_PTR, RST_TBL_PTR, RST_TBL_PTR};
            rom_bank_select <= RST_BANK;
        end else begin
            if (we_low) begin
                ptr.low <= hwdata[7:0];
            end
            if (we_mid) begin
                ptr.mid <= hwdata[7:0];
            end
            if (we_high) begin
                ptr.high <= hwdata[7:0];
            end
            if (we_bank) begin
                rom_bank_select <= hwdata[7:0];
            end
        end
    end

    // Fetch bank moves only at a completed jump, call or interrupt entry
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_bank <= RST_BANK[BANK_SEL_W-1:0];
        end else if (branch_done) begin
            active_bank <= bank_eff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_pend <= 1'b0;
            sw_kind <= 1'b0;
        end else begin
            sw_pend <= next_sw_pend;
            if (we_cmd) begin
                sw_kind <= hwdata[CMD_LAST_PAGE_BIT];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            rom_addr <= '0;
        end else begin
            state <= next_state;
            rom_addr <= next_rom_addr;
        end
    end

    // The high byte is only ever loaded by a table read, never by the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tbl_done <= 1'b0;
            tbl_low_byte <= 8'h00;
            table_high_byte <= 8'h00;
        end else begin
            tbl_done <= state == ST_DATA;
            if (state == ST_DATA) begin
                tbl_low_byte <= rom_data[7:0];
                table_high_byte <= rom_data[15:8];
            end
        end
    end

    // Named copy of the variant mask so assertions can slice it
    wire [ROM_ADDR_W-1:0] addr_mask = low_mask(ADDR_WIDTH);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_bank_hold: assert property (!branch_done |=> $stable(active_bank))
        else $error("active bank moved without a branch");
    a_bank_switch: assert property (branch_done |=> active_bank == $past(rom_bank_select[BANK_SEL_W-1:0]))
        else $error("active bank did not follow the bank pointer");
    a_bank_write: assert property (we_bank |=> rom_bank_select == $past(hwdata[7:0]))
        else $error("bank pointer write lost");
    a_fetch_window: assert property ((idle && !start) |=> (rom_addr == (low_mask(ADDR_WIDTH)
        & {$past(active_bank), $past(pc_low)})))
        else $error("fetch address outside selected bank window");
    a_cur_addr: assert property ((start && !start_kind) |=> rom_addr == (low_mask(ADDR_WIDTH)
        & {$past(ptr.high[1:0]), $past(ptr.mid), $past(ptr.low)}))
        else $error("current table address mismatch");
    a_last_page: assert property ((start && start_kind) |=> rom_addr[12:0] == {LAST_PAGE_SEL, $past(ptr.low)})
        else $error("last page table address mismatch");
    a_width_cut: assert property ((rom_addr & ~low_mask(ADDR_WIDTH)) == '0)
        else $error("ROM address above variant width");
    a_read_cycles: assert property (start |=> tbl_busy ##1 tbl_busy ##1 (tbl_done && !tbl_busy))
        else $error("table read did not finish in two cycles");
    a_read_bytes: assert property (tbl_done |-> table_high_byte == $past(rom_data[15:8])
        && tbl_low_byte == $past(rom_data[7:0]))
        else $error("table read bytes mismatch");
    a_high_ro: assert property ($changed(table_high_byte) |-> tbl_done)
        else $error("table high byte changed outside a table read");
    a_bank_count: assert property (1'b1 |-> (BANK_COUNT << PAGE_BITS) <= (1 << ADDR_WIDTH))
        else $error("bank count does not fit the address width");
    a_mask_high: assert property ((start && !start_kind && ptr.high[7:2] != 6'h00) |=>
        rom_addr[17:16] == ($past(ptr.high[1:0]) & addr_mask[17:16]))
        else $error("upper pointer bits leaked into the address");

    c_cur_read: cover property (start && !start_kind ##2 tbl_done);
    c_last_read: cover property (start && start_kind ##2 tbl_done);
    c_bank_change: cover property (we_bank ##[1:20] branch_done);
    c_sw_read: cover property (we_cmd ##[1:4] sw_taken);
endmodule : rom_bank_table

// ==== test/prog_rom_model.sv ====
// Purpose: Synchronous program ROM seen by the table logic.
// Assumes: One cycle of read latency.
// Notes: Each word is its low address bits folded with a constant and bits 17:16, so locations within 64K words differ.
`timescale 1ns/100ps
module prog_rom_model
    import rom_bank_pkg::*;
#(
    parameter logic [15:0] FOLD = 16'h5A3C
) (
    // Clock
    input wire logic hclk,
    // ROM port
    input wire logic [ROM_ADDR_W-1:0] rom_addr,
    output logic [15:0] rom_data
);
    always_ff @(posedge hclk) begin
        rom_data <= rom_addr[15:0] ^ FOLD ^ {14'h0, rom_addr[17:16]};
    end
endmodule : prog_rom_model

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for ROM bank selection and table reads.
// Assumes: 16-bit variant with 8 banks, so the width cut is exercised.
// Notes: Drivers queue expected words; a monitor compares them as results appear.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    import rom_bank_pkg::*;
    localparam logic [17:0] AMASK = 18'h0FFFF;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_pend;
    logic [31:0] haddr, hwdata, hrdata, er;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic branch_done, tbl_req, tbl_last_page, tbl_busy, fetch_stall, tbl_done;
    logic [PAGE_BITS-1:0] pc_low;
    logic [7:0] tbl_low_byte, table_high_byte;
    logic [ROM_ADDR_W-1:0] rom_addr;
    logic [15:0] rom_data, ew;
    logic [31:0] rd_q[$];
    logic [15:0] tw_q[$];
    int mismatches = 0;
    int num_checks = 0;
    assign hready = hreadyout;
    rom_bank_table #(.ADDR_WIDTH(16), .BANK_COUNT(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .branch_done(branch_done), .pc_low(pc_low),
        .tbl_req(tbl_req), .tbl_last_page(tbl_last_page), .tbl_busy(tbl_busy), .fetch_stall(fetch_stall),
        .tbl_done(tbl_done), .tbl_low_byte(tbl_low_byte), .table_high_byte(table_high_byte),
        .rom_addr(rom_addr), .rom_data(rom_data));
    prog_rom_model rom (.hclk(hclk), .rom_addr(rom_addr), .rom_data(rom_data));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // Expected ROM word; bits above the variant width never reach the ROM
    function automatic logic [15:0] word_at(input logic [17:0] a);
        logic [17:0] m;
        m = a & AMASK;
        return m[15:0] ^ 16'h5A3C ^ {14'h0, m[17:16]};
    endfunction : word_at
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n++ < 50) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n++ < 100) @(posedge hclk);
        if (hreadyout !== 1'b1) mismatches++;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(a, 1'b1, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    // Starts a table read from the CPU port and checks its two-cycle completion
    task automatic tread(input logic last, input logic [15:0] e);
        tw_q.push_back(e);
        @(posedge hclk);
        tbl_req <= 1'b1;
        tbl_last_page <= last;
        #1 `CHK(fetch_stall, 1'b1)
        @(posedge hclk);
        tbl_req <= 1'b0;
        #1 `CHK(tbl_busy, 1'b1)
        repeat (2) @(posedge hclk);
        #1 `CHK(tbl_done, 1'b1)
    endtask : tread
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    always @(posedge hclk) begin
        if (rd_pend && hreadyout === 1'b1 && rd_q.size() > 0) begin
            er = rd_q.pop_front();
            `CHK(hrdata, er)
            `CHK(hresp, 1'b0)
        end
        if (tbl_done === 1'b1 && tw_q.size() > 0) begin
            ew = tw_q.pop_front();
            `CHK({table_high_byte, tbl_low_byte}, ew)
        end
        if (hreadyout === 1'b1) rd_pend <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
    end
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
    initial begin
        logic [7:0] lo, mi, hi, bk, abk;
        logic [15:0] cw;
        {hsel, hwrite, htrans, haddr, hwdata, rd_pend} = '0;
        {hresetn, branch_done, tbl_req, tbl_last_page} = '0;
        hsize = 3'h2;
        pc_low = '0;
        void'($urandom(75696));
        hsel = 1'b1;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd(32'hB4, 32'h0);
        rd(32'h3FC, 32'h0);
        abk = 8'h0;
        for (int i = 0; i < 12; i++) begin
            {lo, mi, hi, bk} = $urandom;
            pc_low <= 13'($urandom);
            wr(32'h1C, lo);
            wr(32'hAC, mi);
            wr(32'hB0, hi);
            wr(32'hB4, bk);
            rd(32'hB4, {24'h0, bk});
            cw = word_at({hi[1:0], mi, lo});
            tread(1'b0, cw);
            // New pointer must not reach the ROM before a branch
            tread(1'b1, word_at({abk[4:0], 5'h1F, lo}));
            @(posedge hclk);
            branch_done <= 1'b1;
            @(posedge hclk);
            branch_done <= 1'b0;
            abk = bk;
            @(posedge hclk);
            #1 `CHK(rom_addr, ({abk[4:0], pc_low} & AMASK))
            ew = word_at({abk[4:0], 5'h1F, lo});
            tread(1'b1, ew);
            rd(32'h20, {24'h0, ew[15:8]});
            wr(32'h20, ~ew[15:8]);
            rd(32'h20, {24'h0, ew[15:8]});
            // Software-started read of the full pointer
            tw_q.push_back(cw);
            wr(32'h100, 8'h01);
            repeat (4) @(posedge hclk);
            rd(32'h104, {24'h0, cw[7:0]});
        end
        repeat (4) @(posedge hclk);
        `CHK(rd_q.size() + tw_q.size(), 0)
        end_sim();
    end
endmodule : tb_top
